// file: hdl/eei_pkg.sv
// Purpose : shared constants and types of the external edge interrupt unit
// Assumes : one clock domain, synchronous active-low reset
// Notes   : source numbering is fixed here and used by the unit and the test files
package eei_pkg;

    // ------------------------------------------------------------
    // source counts and numbering
    // ------------------------------------------------------------
    localparam int unsigned EEI_NUM_WAKEUP  = 8;
    localparam int unsigned EEI_NUM_REQ     = 4;
    localparam int unsigned EEI_NUM_SOURCES = 13;
    localparam int unsigned EEI_IDX_W       = 4;
    localparam int unsigned EEI_REQ_FLAGS   = 5;
    localparam int unsigned EEI_PC_W        = 16;
    localparam int unsigned EEI_CCR_W       = 8;

    localparam logic [3:0] EEI_SRC_WAKE_BASE = 4'h0;
    localparam logic [3:0] EEI_SRC_REQ_BASE  = 4'h8;
    localparam logic [3:0] EEI_SRC_EVENT     = 4'hC;

    // position of the event flag in the first request register
    localparam int unsigned EEI_EVENT_FLAG_POS = 4;

    // ------------------------------------------------------------
    // edge selection encodings
    // ------------------------------------------------------------
    localparam logic       EEI_EDGE_FALLING = 1'b0;
    localparam logic       EEI_EDGE_RISING  = 1'b1;
    localparam logic [1:0] EEI_EVT_FALLING  = 2'b00;
    localparam logic [1:0] EEI_EVT_RISING   = 2'b01;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] EEI_WAKE_FLAG_RESET = 8'h00;
    localparam logic [4:0] EEI_REQ_FLAG_RESET  = 5'h00;
    localparam logic       EEI_MASK_RESET      = 1'b1;

    // ------------------------------------------------------------
    // vector table layout (plain defaults)
    // ------------------------------------------------------------
    localparam logic [15:0] EEI_VECTOR_BASE = 16'h0008;
    localparam logic [15:0] EEI_VECTOR_STEP = 16'h0002;

    typedef struct packed {
        logic [7:0] wakeup_edge_select_reg;
        logic [7:0] port5_function_reg;
        logic [3:0] edge_select_reg;
        logic [3:0] pin_function;
        logic [1:0] event_edge_select_reg;
        logic       event_pwm_enable_bit;
    } eei_config_type;

    typedef struct packed {
        logic       wakeup_enable_bit;
        logic [3:0] pin_enable;
        logic       event_interrupt_enable_bit;
    } eei_enable_type;

    typedef struct packed {
        logic [15:0] pc;
        logic [7:0]  ccr;
    } eei_cpu_state_type;

    typedef enum logic [2:0] {
        ACC_IDLE,
        ACC_PUSH_PC,
        ACC_PUSH_CCR,
        ACC_MASK,
        ACC_VECTOR
    } eei_accept_state_type;

endpackage

// file: hdl/eei_edge_detect.sv
// Purpose : clean one input level and report its rising and falling edges
// Assumes : SYNCED=1 for pins from outside the clock domain
// Notes   : the first settled level after reset gives no edge
module eei_edge_detect #(
    parameter bit SYNCED = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic [2:0] sync_reg;
    logic [2:0] fill_reg;
    logic       level_reg;
    logic       primed_reg;
    logic       rise_reg;
    logic       fall_reg;
    logic       level_next;
    logic       settled;

    // fill marks which stages hold real samples; a low idle pin must
    // still see its first rise after reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync_reg <= 3'h0;
            fill_reg <= 3'h0;
        end else begin
            sync_reg <= {sync_reg[1:0], pin_in};
            fill_reg <= {fill_reg[1:0], 1'b1};
        end
    end

    // only the second and third stages are compared
    assign settled    = SYNCED ? (sync_reg[1] == sync_reg[2]) : 1'b1;
    assign level_next = SYNCED ? (settled ? sync_reg[2] : level_reg)
                               : pin_in;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            level_reg  <= 1'b0;
            primed_reg <= 1'b0;
            rise_reg   <= 1'b0;
            fall_reg   <= 1'b0;
        end else begin
            level_reg  <= level_next;
            primed_reg <= primed_reg | (settled & (fill_reg[2] | !SYNCED));
            rise_reg   <= primed_reg & level_next & !level_reg;
            fall_reg   <= primed_reg & !level_next & level_reg;
        end
    end

    assign level = level_reg;
    assign rise  = rise_reg;
    assign fall  = fall_reg;
endmodule

// file: hdl/eei_priority.sv
// Purpose : pick the highest ranked pending source
// Assumes : ORDER lists source numbers, rank 0 first
// Notes   : purely combinational
module eei_priority #(
    parameter int unsigned N     = 13,
    parameter int unsigned IDX_W = 4,
    parameter logic [N-1:0][IDX_W-1:0] ORDER = '0
) (
    input  wire logic [N-1:0]     pending,
    output logic                  any,
    output logic [IDX_W-1:0]      winner
);
    initial begin
        if (N > (1 << IDX_W)) begin
            $error("eei_priority: IDX_W too narrow for N");
        end
    end

    always_comb begin
        any    = 1'b0;
        winner = '0;
        // walk from lowest rank up so the best rank is written last
        for (int r = N - 1; r >= 0; r--) begin
            if (pending[ORDER[r]]) begin
                any    = 1'b1;
                winner = ORDER[r];
            end
        end
    end
endmodule

// file: hdl/eei_unit.sv
// Purpose : thirteen-source external edge interrupt unit with acceptance
// Assumes : cpu signals come from logic on clk; pins are asynchronous
// Notes   : request pins bits 0..3 are numbered pins 0, 1, 3, 4
//
// Notes on behaviour
// - thirteen sources: eight wakeup, four pins, event
// - wakeup edge chosen per pin
// - wakeup pin active only with function bit set
// - wakeup edge sets its flag, raises request
// - wakeup enable zero blocks wakeup acceptance
// - each request pin has own edge bit
// - enabled pin edge sets its request flag
// - pin enable zero blocks that pin's acceptance
// - event edge: rising, falling or both
// - enabled event edge sets event flag
// - mask bit one masks every source
// - enabled event request sets matching flag
// - only highest priority request presented
// - accept when mask zero, else hold pending
// - after instruction, push pc then ccr
// - after stacking, mask bit set to one
// - fetch vector for accepted source
// - acceptance waits until clearing instruction completes
// - edge bit zero falling, one rising
module eei_unit
    import eei_pkg::*;
#(
    parameter logic [12:0][3:0] PRIORITY_ORDER = {
        4'hC, 4'hB, 4'hA, 4'h9, 4'h8, 4'h7, 4'h6,
        4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0}
) (
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire logic [7:0]                  wakeup_pins,
    input  wire logic [3:0]                  request_pins,
    input  wire logic                        event_counter_interrupt,
    input  wire logic                        event_counter_pwm_signal,
    input  wire eei_pkg::eei_config_type     cfg,
    input  wire eei_pkg::eei_enable_type     first_enable_reg,
    input  wire logic [7:0]                  wakeup_flag_clear,
    input  wire logic [4:0]                  request_flag_clear,
    input  wire logic                        mask_write,
    input  wire logic                        mask_wdata,
    input  wire logic                        instr_done,
    input  wire logic                        clear_instr_busy,
    input  wire eei_pkg::eei_cpu_state_type  cpu_state,
    output logic [7:0]                       wakeup_flag_reg,
    output logic [4:0]                       first_request_reg,
    output logic                             intr_mask_reg,
    output logic                             irq_presented,
    output logic [3:0]                       irq_source,
    output logic                             stack_write,
    output logic [15:0]                      stack_word,
    output logic                             vector_fetch,
    output logic [15:0]                      vector_addr,
    output logic                             accept_busy
);
    import eei_pkg::*;

    initial begin
        if (EEI_NUM_WAKEUP + EEI_NUM_REQ + 1 != EEI_NUM_SOURCES) begin
            $error("eei_unit: source count mismatch");
        end
    end

    // ------------------------------------------------------------
    // pin conditioning
    // ------------------------------------------------------------
    logic [12:0] pin_vec;
    logic [12:0] pin_rise;
    logic [12:0] pin_fall;
    logic        pwm_rise;
    logic        pwm_fall;

    assign pin_vec = {event_counter_interrupt, request_pins, wakeup_pins};

    for (genvar g = 0; g < 13; g++) begin : g_pin
        eei_edge_detect #(.SYNCED(1'b1)) u_edge (
            .clk    (clk),
            .rst_b  (rst_b),
            .pin_in (pin_vec[g]),
            .level  (),
            .rise   (pin_rise[g]),
            .fall   (pin_fall[g])
        );
    end

    // internal pwm already runs on clk, so no synchroniser
    eei_edge_detect #(.SYNCED(1'b0)) u_pwm_edge (
        .clk    (clk),
        .rst_b  (rst_b),
        .pin_in (event_counter_pwm_signal),
        .level  (),
        .rise   (pwm_rise),
        .fall   (pwm_fall)
    );

    // ------------------------------------------------------------
    // edge selection
    // ------------------------------------------------------------
    logic [7:0] wake_hit;
    logic [3:0] req_hit;
    logic       evt_rise;
    logic       evt_fall;
    logic       evt_hit;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            wake_hit[i] = cfg.port5_function_reg[i] &
                (cfg.wakeup_edge_select_reg[i] == EEI_EDGE_RISING
                    ? pin_rise[i] : pin_fall[i]);
        end
        for (int j = 0; j < 4; j++) begin
            req_hit[j] = cfg.pin_function[j] &
                (cfg.edge_select_reg[j] == EEI_EDGE_FALLING
                    ? pin_fall[8 + j] : pin_rise[8 + j]);
        end
    end

    // pwm enable picks the internal signal over the pin
    assign evt_rise = cfg.event_pwm_enable_bit ? pwm_rise : pin_rise[12];
    assign evt_fall = cfg.event_pwm_enable_bit ? pwm_fall : pin_fall[12];

    always_comb begin
        unique case (cfg.event_edge_select_reg)
            EEI_EVT_FALLING: evt_hit = evt_fall;
            EEI_EVT_RISING:  evt_hit = evt_rise;
            default:         evt_hit = evt_rise | evt_fall;
        endcase
    end

    // ------------------------------------------------------------
    // request flags
    // ------------------------------------------------------------
    logic [4:0] req_set;
    logic       evt_set;

    assign evt_set = evt_hit & first_enable_reg.event_interrupt_enable_bit;
    assign req_set = {evt_set, req_hit};

    // a set in the same cycle as a clear wins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wakeup_flag_reg <= EEI_WAKE_FLAG_RESET;
        end else begin
            wakeup_flag_reg <= (wakeup_flag_reg & ~wakeup_flag_clear)
                             | wake_hit;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            first_request_reg <= EEI_REQ_FLAG_RESET;
        end else begin
            first_request_reg <= (first_request_reg & ~request_flag_clear)
                               | req_set;
        end
    end

    // ------------------------------------------------------------
    // priority and presentation
    // ------------------------------------------------------------
    logic [12:0] pending;
    logic        any_pending;
    logic [3:0]  winner;
    logic        clear_active;

    assign pending = {
        first_request_reg[EEI_EVENT_FLAG_POS]
            & first_enable_reg.event_interrupt_enable_bit,
        first_request_reg[3:0] & first_enable_reg.pin_enable,
        wakeup_flag_reg & {8{first_enable_reg.wakeup_enable_bit}}
    };

    eei_priority #(
        .N     (EEI_NUM_SOURCES),
        .IDX_W (EEI_IDX_W),
        .ORDER (PRIORITY_ORDER)
    ) u_prio (
        .pending (pending),
        .any     (any_pending),
        .winner  (winner)
    );

    assign irq_presented = any_pending & !intr_mask_reg;
    assign irq_source    = winner;

    // a clearing instruction in flight defers acceptance
    assign clear_active = clear_instr_busy | (|wakeup_flag_clear)
                        | (|request_flag_clear);

    // ------------------------------------------------------------
    // acceptance sequence
    // ------------------------------------------------------------
    eei_accept_state_type state_reg;
    eei_accept_state_type state_next;
    logic                 accept;
    logic [3:0]           taken_reg;
    logic [7:0]           saved_ccr_reg;
    logic [15:0]          saved_pc_reg;

    assign accept = (state_reg == ACC_IDLE) & irq_presented
                  & instr_done & !clear_active;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ACC_IDLE:     if (accept) state_next = ACC_PUSH_PC;
            ACC_PUSH_PC:  state_next = ACC_PUSH_CCR;
            ACC_PUSH_CCR: state_next = ACC_MASK;
            ACC_MASK:     state_next = ACC_VECTOR;
            ACC_VECTOR:   state_next = ACC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= ACC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // pc captured at the boundary is the return address
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            taken_reg     <= 4'h0;
            saved_pc_reg  <= 16'h0000;
            saved_ccr_reg <= 8'h00;
        end else if (accept) begin
            taken_reg     <= winner;
            saved_pc_reg  <= cpu_state.pc;
            saved_ccr_reg <= cpu_state.ccr;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stack_write <= 1'b0;
            stack_word  <= 16'h0000;
        end else begin
            stack_write <= (state_reg == ACC_PUSH_PC)
                         | (state_reg == ACC_PUSH_CCR);
            if (state_reg == ACC_PUSH_PC) begin
                stack_word <= saved_pc_reg;
            end else if (state_reg == ACC_PUSH_CCR) begin
                stack_word <= {8'h00, saved_ccr_reg};
            end
        end
    end

    // hardware set wins over a software write in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            intr_mask_reg <= EEI_MASK_RESET;
        end else if (state_reg == ACC_MASK) begin
            intr_mask_reg <= 1'b1;
        end else if (mask_write) begin
            intr_mask_reg <= mask_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            vector_fetch <= 1'b0;
            vector_addr  <= EEI_VECTOR_BASE;
        end else begin
            vector_fetch <= (state_reg == ACC_VECTOR);
            if (state_reg == ACC_VECTOR) begin
                vector_addr <= EEI_VECTOR_BASE
                             + EEI_VECTOR_STEP * {12'h000, taken_reg};
            end
        end
    end

    assign accept_busy = (state_reg != ACC_IDLE);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_stack_pc;
        stack_write && stack_word == saved_pc_reg;
    endsequence

    sequence s_stack_ccr;
        stack_write && stack_word == {8'h00, saved_ccr_reg};
    endsequence

    sequence s_masked_vector;
        intr_mask_reg ##1 vector_fetch
            && vector_addr == EEI_VECTOR_BASE
                + EEI_VECTOR_STEP * {12'h000, taken_reg};
    endsequence

    a_wake_flag_set: assert property (
        @(posedge clk) disable iff (!rst_b)
        wake_hit[0] |=> wakeup_flag_reg[0])
        else $error("wakeup edge did not set flag");

    a_wake_func_gate: assert property (
        @(posedge clk) disable iff (!rst_b)
        !cfg.port5_function_reg[1] |-> !wake_hit[1])
        else $error("wakeup edge seen without pin function");

    a_pin_flag_set: assert property (
        @(posedge clk) disable iff (!rst_b)
        req_hit[0] |=> first_request_reg[0])
        else $error("request pin edge did not set flag");

    a_event_flag_set: assert property (
        @(posedge clk) disable iff (!rst_b)
        $rose(first_request_reg[EEI_EVENT_FLAG_POS])
            |-> $past(first_enable_reg.event_interrupt_enable_bit))
        else $error("event flag set while disabled");

    a_flag_holds: assert property (
        @(posedge clk) disable iff (!rst_b)
        first_request_reg[1] && !request_flag_clear[1]
            |=> first_request_reg[1])
        else $error("request flag dropped without clear");

    a_mask_blocks: assert property (
        @(posedge clk) disable iff (!rst_b)
        intr_mask_reg |-> !accept && !irq_presented)
        else $error("request accepted while masked");

    a_enable_gate: assert property (
        @(posedge clk) disable iff (!rst_b)
        accept |-> pending[winner])
        else $error("accepted a disabled source");

    a_clear_defers: assert property (
        @(posedge clk) disable iff (!rst_b)
        clear_active |-> !accept)
        else $error("accepted during clearing instruction");

    a_accept_steps: assert property (
        @(posedge clk) disable iff (!rst_b)
        accept |=> ##1 s_stack_pc ##1 s_stack_ccr ##1 s_masked_vector)
        else $error("acceptance sequence out of order");

    a_vector_once: assert property (
        @(posedge clk) disable iff (!rst_b)
        vector_fetch |=> !vector_fetch [*3])
        else $error("vector fetched twice in a row");

endmodule

// file: test/eei_cpu_model.sv
// Purpose : cpu core stand-in: instruction boundaries, clearing, pc and ccr
// Assumes : one clock, synchronous active-low reset
// Notes   : pc and ccr come from the bench so stacked words are known
module eei_cpu_model
    import eei_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  slow,
    input  wire logic                  hold_clear,
    input  wire logic [15:0]           pc_value,
    input  wire logic [7:0]            ccr_value,
    output logic                       instr_done,
    output logic                       clear_instr_busy,
    output eei_pkg::eei_cpu_state_type cpu_state
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] phase_reg;

    // slow mode: a boundary only every third cycle
    always_ff @(posedge clk) begin
        if (!rst_b || !slow || phase_reg == 2'h2) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    assign instr_done       = rst_b && phase_reg == 2'h0;
    assign clear_instr_busy = hold_clear;
    assign cpu_state.pc     = pc_value;
    assign cpu_state.ccr    = ccr_value;
endmodule

// file: test/tb_top.sv
// Purpose : self-checking bench for the external edge interrupt unit
// Assumes : inputs driven at the falling edge, default priority order
// Notes   : flag waits of 8 cycles cover the 5-edge pin path
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import eei_pkg::*;

    logic              clk;
    logic              rst_b;
    logic [7:0]        wk_pins;
    logic [3:0]        rq_pins;
    logic              ev_pin;
    logic              pwm_sig;
    eei_config_type    cfg;
    eei_enable_type    en;
    logic [7:0]        wk_clr;
    logic [4:0]        rq_clr;
    logic              mask_write;
    logic              mask_wdata;
    logic              slow;
    logic              hold_clear;
    logic [15:0]       pc_value;
    logic [7:0]        ccr_value;
    logic              instr_done;
    logic              clear_busy;
    eei_cpu_state_type cpu_state;
    logic [7:0]        wk_flags;
    logic [4:0]        rq_flags;
    logic              mask;
    logic              presented;
    logic [3:0]        source;
    logic              stack_write;
    logic [15:0]       stack_word;
    logic              vector_fetch;
    logic [15:0]       vector_addr;
    logic              accept_busy;
    int                bad_count;
    int                tests_run;

    eei_unit eei_unit_inst (
        .clk(clk), .rst_b(rst_b), .wakeup_pins(wk_pins),
        .request_pins(rq_pins), .event_counter_interrupt(ev_pin),
        .event_counter_pwm_signal(pwm_sig), .cfg(cfg),
        .first_enable_reg(en), .wakeup_flag_clear(wk_clr),
        .request_flag_clear(rq_clr), .mask_write(mask_write),
        .mask_wdata(mask_wdata), .instr_done(instr_done),
        .clear_instr_busy(clear_busy), .cpu_state(cpu_state),
        .wakeup_flag_reg(wk_flags), .first_request_reg(rq_flags),
        .intr_mask_reg(mask), .irq_presented(presented),
        .irq_source(source), .stack_write(stack_write),
        .stack_word(stack_word), .vector_fetch(vector_fetch),
        .vector_addr(vector_addr), .accept_busy(accept_busy)
    );

    eei_cpu_model eei_cpu_model_inst (
        .clk(clk), .rst_b(rst_b), .slow(slow), .hold_clear(hold_clear),
        .pc_value(pc_value), .ccr_value(ccr_value),
        .instr_done(instr_done), .clear_instr_busy(clear_busy),
        .cpu_state(cpu_state)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // clearing only while masked avoids racing a new request
    task automatic clear_flags();
        wk_clr = 8'hFF;
        rq_clr = 5'h1F;
        cyc(1);
        wk_clr = 8'h00;
        rq_clr = 5'h00;
        cyc(1);
        chk("flags cleared", 16'h0000, {3'h0, rq_flags, wk_flags});
    endtask

    task automatic accept(input logic [3:0] src, input bit hold);
        logic [15:0] words[$];
        int          n;
        pc_value   = 16'h4000 + {12'h000, src};
        hold_clear = hold;
        mask_wdata = 1'b0;
        mask_write = 1'b1;
        cyc(1);
        mask_write = 1'b0;
        cyc(1);
        chk("presented", 16'h0001, {15'h0, presented});
        chk("winner", {12'h000, src}, {12'h000, source});
        n = 0;
        while (!vector_fetch && n < 30) begin
            if (stack_write) begin
                words.push_back(stack_word);
                chk("busy", 16'h0001, {15'h0, accept_busy});
            end
            if (hold && n == 6) begin
                chk("deferred", 16'h0000, 16'(words.size()));
                hold_clear = 1'b0;
            end
            cyc(1);
            n++;
        end
        if (n == 30) begin
            bad_count++;
            report_and_stop();
        end
        chk("stack count", 16'h0002, 16'(words.size()));
        chk("stack pc", pc_value, words[0]);
        chk("stack ccr", {8'h00, ccr_value}, words[1]);
        chk("vector", EEI_VECTOR_BASE + EEI_VECTOR_STEP * src,
            vector_addr);
        chk("mask set", 16'h0001, {15'h0, mask});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        chk("reset flags", 16'h0000, {3'h0, rq_flags, wk_flags});
        chk("reset mask", 16'h0001, {15'h0, mask});
        chk("reset vector", EEI_VECTOR_BASE, vector_addr);
        chk("reset outs", 16'h0000,
            {12'h000, presented, accept_busy, stack_write, vector_fetch});
    endtask

    task automatic t_wakeup();
        wk_pins = 8'hFF;
        cyc(8);
        chk("wake no function", 16'h0000, {8'h00, wk_flags});
        cfg.port5_function_reg     = 8'hFF;
        cfg.wakeup_edge_select_reg = 8'h55;
        cyc(2);
        wk_pins = 8'h00;
        cyc(8);
        chk("wake fall", 16'h00AA, {8'h00, wk_flags});
        wk_pins = 8'hFF;
        cyc(8);
        chk("wake rise", 16'h00FF, {8'h00, wk_flags});
        clear_flags();
    endtask

    task automatic t_request();
        rq_pins = 4'h0;
        cyc(8);
        rq_pins = 4'hF;
        cyc(8);
        chk("pin no function", 16'h0000, {11'h0, rq_flags});
        cfg.pin_function    = 4'hF;
        cfg.edge_select_reg = 4'h5;
        cyc(2);
        rq_pins = 4'h0;
        cyc(8);
        chk("pin fall", 16'h000A, {11'h0, rq_flags});
        rq_pins = 4'hF;
        cyc(8);
        chk("pin rise", 16'h000F, {11'h0, rq_flags});
        clear_flags();
    endtask

    task automatic t_event();
        ev_pin = 1'b1;
        cyc(8);
        ev_pin = 1'b0;
        cyc(8);
        chk("event off", 16'h0000, {11'h0, rq_flags});
        en.event_interrupt_enable_bit = 1'b1;
        for (int c = 0; c < 4; c++) begin
            cfg.event_edge_select_reg = 2'(c);
            ev_pin = 1'b1;
            cyc(8);
            chk("event rise", {15'h0, c != 0}, {15'h0, rq_flags[4]});
            clear_flags();
            ev_pin = 1'b0;
            cyc(8);
            chk("event fall", {15'h0, c != 1}, {15'h0, rq_flags[4]});
            clear_flags();
        end
        cfg.event_pwm_enable_bit  = 1'b1;
        cfg.event_edge_select_reg = EEI_EVT_RISING;
        ev_pin = 1'b1;
        cyc(8);
        chk("pin unselected", 16'h0000, {15'h0, rq_flags[4]});
        pwm_sig = 1'b1;
        cyc(8);
        chk("pwm edge", 16'h0001, {15'h0, rq_flags[4]});
        pwm_sig = 1'b0;
        ev_pin  = 1'b0;
        cyc(2);
        cfg.event_pwm_enable_bit = 1'b0;
        clear_flags();
    endtask

    task automatic t_accept();
        en = '1;
        wk_pins[5] = 1'b0;
        rq_pins[1] = 1'b0;
        ev_pin     = 1'b1;
        cyc(10);
        chk("masked", 16'h0000, {14'h0, presented, accept_busy});
        accept(4'h5, 1'b0);
        chk("flags kept", 16'h1220, {3'h0, rq_flags, wk_flags});
        en.wakeup_enable_bit = 1'b0;
        slow = 1'b1;
        accept(4'h9, 1'b0);
        en.pin_enable[1] = 1'b0;
        accept(4'hC, 1'b1);
        slow = 1'b0;
        clear_flags();
    endtask

    initial begin
        rst_b      = 1'b0;
        wk_pins    = 8'h00;
        rq_pins    = 4'hF;
        ev_pin     = 1'b0;
        pwm_sig    = 1'b0;
        cfg        = '0;
        en         = '0;
        wk_clr     = 8'h00;
        rq_clr     = 5'h00;
        mask_write = 1'b0;
        mask_wdata = 1'b1;
        slow       = 1'b0;
        hold_clear = 1'b0;
        pc_value   = 16'h1A2C;
        ccr_value  = 8'h0A;
        bad_count  = 0;
        tests_run  = 0;
        cyc(5);
        rst_b = 1'b1;
        cyc(2);
        t_reset();
        t_wakeup();
        t_request();
        t_event();
        t_accept();
        report_and_stop();
    end
endmodule
